/* acc_ctrl.sv */
// converter control: registers, completion flag, phase control
//
// Summary of operation
// - each conversion is a sampling phase then an eight-tick hold
// - while on, sample and hold repeat back to back
// - setting the on bit powers up and starts the selected channel
// - completion stores the result and sets flag bit 7
// - flag clears on high result read or any control write
// - a channel change abandons, clears the flag and restarts
// - any control write while on aborts, clears flag, restarts
// - clearing bit 5 powers the converter down, no conversions
// - cpu wait mode leaves conversions untouched
// - halt disables the converter; software waits after wakeup
// - bit 7 read only, 6 rate, 5 on, 4:3 reserved zero
// - channel codes 000 to 100 select inputs zero to four
// - converter clock is cpu/2, cpu, or cpu/4 when slow set
// - high result byte shows result bits 9 to 2
// - low byte shows result 1:0 and slow at bit 3, rest zero
// - reset clears all five registers to zero
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module acc_ctrl
    import acc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              halt_mode,
    input  wire logic [RES_W-1:0]  ana_result,
    output logic                   ana_power,
    output logic      [CH_W-1:0]   ana_channel,
    output logic                   ana_sample,
    output logic                   ana_hold,
    output logic                   irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic             on;
        logic             rate;
        logic [CH_W-1:0]  chan;
        logic             flag;
        logic             slow;
        logic [RES_W-1:0] res;
        logic             ist;
        logic             imsk;
        logic [7:0]       rdata;
        logic             run_prev;
    } acc_ctrl_st_t;

    acc_ctrl_st_t s_q;
    acc_ctrl_st_t s_d;

    acc_seq_if sif ();

    logic csr_wr;
    logic lo_wr;
    logic ist_wr;
    logic msk_wr;
    logic hi_rd;
    logic run;
    logic restart;
    logic done_ok;

    // ------------------------------------------------------------
    // sub blocks
    // ------------------------------------------------------------
    acc_tick_gen u_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .t       (sif.gen)
    );

    acc_phase_seq #(
        .SAMPLE_N (SAMPLE_TICKS),
        .HOLD_N   (HOLD_TICKS)
    ) u_seq (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .t       (sif.seq)
    );

    // ------------------------------------------------------------
    // access decode and phase control
    // ------------------------------------------------------------
    assign csr_wr = reg_wr && (reg_addr == OFS_CSR);
    assign lo_wr  = reg_wr && (reg_addr == OFS_RES_LO);
    assign ist_wr = reg_wr && (reg_addr == OFS_IRQ_STAT);
    assign msk_wr = reg_wr && (reg_addr == OFS_IRQ_MASK);
    assign hi_rd  = reg_rd && (reg_addr == OFS_RES_HI);

    // cpu wait is not an input here
    assign run = s_q.on && !halt_mode;

    assign restart = (csr_wr && s_q.on) || (run && !s_q.run_prev);

    // a conversion abandoned by a control write never completes
    assign done_ok = sif.done && !csr_wr;

    assign sif.run     = run;
    assign sif.restart = restart;
    assign sif.slow    = s_q.slow;
    assign sif.rate    = s_q.rate;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.run_prev = run;
        if (csr_wr) begin
            s_d.on   = reg_wdata[CSR_ON];
            s_d.rate = reg_wdata[CSR_RATE];
            s_d.chan = reg_wdata[CH_W-1:0];
        end
        if (lo_wr) begin
            s_d.slow = reg_wdata[LO_SLOW];
        end
        if (msk_wr) begin
            s_d.imsk = reg_wdata[IRQ_DONE];
        end
        if (hi_rd || csr_wr) begin
            s_d.flag = 1'b0;
        end
        if (ist_wr && reg_wdata[IRQ_DONE]) begin
            s_d.ist = 1'b0;
        end
        if (done_ok) begin
            s_d.res  = ana_result;
            s_d.flag = 1'b1;
            s_d.ist  = 1'b1;
        end
        s_d.rdata = RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CSR: begin
                    s_d.rdata = {s_q.flag, s_q.rate, s_q.on, 2'h0,
                                 s_q.chan};
                end
                OFS_RES_HI: begin
                    s_d.rdata = s_q.res[RES_W-1:2];
                end
                OFS_RES_LO: begin
                    s_d.rdata = {4'h0, s_q.slow, 1'b0, s_q.res[1:0]};
                end
                OFS_IRQ_STAT: begin
                    s_d.rdata = {7'h00, s_q.ist};
                end
                OFS_IRQ_MASK: begin
                    s_d.rdata = {7'h00, s_q.imsk};
                end
                default: begin
                    s_d.rdata = RST_BYTE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // everything clears on reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata   = s_q.rdata;
    assign ana_power   = run;
    assign ana_channel = s_q.chan;
    assign ana_sample  = sif.sample;
    assign ana_hold    = sif.hold;
    assign irq         = s_q.ist && s_q.imsk;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking acc_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // checks: completion flag and result
    // ------------------------------------------------------------
    AST_FLAG_SET: assert property (
        done_ok |=> s_q.flag && s_q.res == $past(ana_result))
        else $error("completion did not load result and flag");

    AST_FLAG_RISE: assert property (
        !s_q.flag && !done_ok |=> !s_q.flag)
        else $error("flag set without a completion");

    AST_RES_KEEP: assert property (
        !done_ok |=> s_q.res == $past(s_q.res))
        else $error("result changed without a completion");

    AST_HI_CLEAR: assert property (
        hi_rd && !done_ok |=> !s_q.flag)
        else $error("high result read left the flag set");

    AST_LO_KEEP: assert property (
        reg_rd && reg_addr == OFS_RES_LO && s_q.flag
        |=> s_q.flag)
        else $error("low result read changed the flag");

    AST_WR_CLEAR: assert property (
        csr_wr |=> !s_q.flag)
        else $error("control write left the flag set");

    AST_FLAG_KEEP: assert property (
        s_q.flag && !hi_rd && !csr_wr |=> s_q.flag)
        else $error("flag dropped without a clearing access");

    // ------------------------------------------------------------
    // checks: conversion control
    // ------------------------------------------------------------
    AST_RESTART: assert property (
        csr_wr && run |=> ana_sample && !ana_hold)
        else $error("control write while on did not restart");

    AST_POWER_UP: assert property (
        csr_wr && reg_wdata[CSR_ON] && !s_q.on ##1 !halt_mode
        |=> ana_sample)
        else $error("setting the on bit did not start sampling");

    AST_OFF_IDLE: assert property (
        !s_q.on |=> !ana_sample && !ana_hold)
        else $error("converter ran while switched off");

    // power follows halt at once, the phases one cycle later
    AST_HALT_IDLE: assert property (
        halt_mode |-> !ana_power ##1 (!ana_sample && !ana_hold))
        else $error("converter ran during halt");

    AST_CONTINUE: assert property (
        sif.done && run && !restart |-> ana_sample)
        else $error("converter stopped after a completion");

    AST_HOLD_ENTRY: assert property (
        $rose(ana_hold) |-> $past(ana_sample))
        else $error("hold phase entered without sampling");

    AST_CHAN_HOLD: assert property (
        !csr_wr |=> ana_channel == $past(ana_channel))
        else $error("channel changed without a control write");

    // ------------------------------------------------------------
    // checks: converter clock
    // ------------------------------------------------------------
    AST_QUARTER: assert property (
        sif.tick && s_q.slow |=> (!sif.tick || !s_q.slow)[*3])
        else $error("quarter rate ticked too fast");

    AST_RATE_FULL: assert property (
        sif.tick && run && s_q.rate && !s_q.slow |=> sif.tick)
        else $error("full rate missed a tick");

    AST_RATE_HALF: assert property (
        sif.tick && !s_q.rate && !s_q.slow |=> !sif.tick)
        else $error("half rate ticked too fast");

    // ------------------------------------------------------------
    // checks: register file
    // ------------------------------------------------------------
    AST_CSR_WR: assert property (
        csr_wr |=> s_q.on == $past(reg_wdata[CSR_ON])
            && s_q.rate == $past(reg_wdata[CSR_RATE])
            && s_q.chan == $past(reg_wdata[CH_W-1:0]))
        else $error("control write did not load its fields");

    AST_SLOW_WR: assert property (
        lo_wr |=> s_q.slow == $past(reg_wdata[LO_SLOW]))
        else $error("low byte write did not load the slow bit");

    AST_HI_DATA: assert property (
        hi_rd |=> reg_rdata == $past(s_q.res[RES_W-1:2]))
        else $error("high result byte wrong");

    AST_LO_DATA: assert property (
        reg_rd && reg_addr == OFS_RES_LO
        |=> reg_rdata[7:4] == 4'h0 && reg_rdata[2] == 1'b0
            && reg_rdata[LO_SLOW] == $past(s_q.slow))
        else $error("low result byte layout wrong");

    AST_CSR_RSVD: assert property (
        reg_rd && reg_addr == OFS_CSR
        |=> reg_rdata[4:3] == 2'h0
            && reg_rdata[CSR_FLAG] == $past(s_q.flag))
        else $error("control read shows reserved bits");

    AST_RDATA_IDLE: assert property (
        !reg_rd |=> reg_rdata == RST_BYTE)
        else $error("read data shown without a read");

    // ------------------------------------------------------------
    // checks: interrupt
    // ------------------------------------------------------------
    AST_NO_IRQ: assert property (
        !s_q.imsk |-> !irq)
        else $error("interrupt raised while masked");

    AST_IRQ_SET: assert property (
        done_ok && s_q.imsk && !msk_wr |=> irq)
        else $error("unmasked completion raised no interrupt");

    AST_IST_CLEAR: assert property (
        ist_wr && reg_wdata[IRQ_DONE] && !done_ok |=> !s_q.ist)
        else $error("status write of one left the status bit set");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    COV_DONE: cover property (done_ok);
    COV_TEN_BIT: cover property (
        s_q.flag ##1 (reg_rd && reg_addr == OFS_RES_LO) ##[1:4] hi_rd);
    COV_CHAN_SWAP: cover property (
        csr_wr && run && reg_wdata[CH_W-1:0] != s_q.chan);
    COV_HALT: cover property (run ##1 halt_mode ##[1:400] !halt_mode);
    COV_IRQ: cover property (irq);
endmodule // acc_ctrl

/* acc_pkg.sv */
// constants and types shared by the converter control block
package acc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 16;
    localparam logic [15:0] OFS_CSR       = 16'h0034;
    localparam logic [15:0] OFS_RES_HI    = 16'h0035;
    localparam logic [15:0] OFS_RES_LO    = 16'h0036;
    localparam logic [15:0] OFS_IRQ_STAT  = 16'h0037;
    localparam logic [15:0] OFS_IRQ_MASK  = 16'h0038;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CSR_FLAG    = 7;
    localparam int CSR_RATE    = 6;
    localparam int CSR_ON      = 5;
    localparam int CH_W        = 3;
    localparam int LO_SLOW     = 3;
    localparam int IRQ_DONE    = 0;
    localparam int RES_W       = 10;
    // ------------------------------------------------------------
    // timing counts: phase lengths in converter clock ticks, divider limits in cpu clocks less one
    // ------------------------------------------------------------
    localparam int SAMPLE_TICKS = 4;
    localparam int HOLD_TICKS   = 8;
    localparam logic [1:0] DIV_FULL_M1    = 2'h0;
    localparam logic [1:0] DIV_HALF_M1    = 2'h1;
    localparam logic [1:0] DIV_QUARTER_M1 = 2'h3;
    // ------------------------------------------------------------
    // conversion phases, gray coded
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_IDLE   = 2'h0,
        ACC_SAMPLE = 2'h1,
        ACC_HOLD   = 2'h3
    } acc_phase_t;
endpackage

/* acc_seq_if.sv */
// link between control, converter clock divider and phase sequencer
`timescale 1ns/1ps
interface acc_seq_if;
    logic tick;
    logic run;
    logic restart;
    logic slow;
    logic rate;
    logic sample;
    logic hold;
    logic done;
    modport ctl (output run, restart, slow, rate,
                 input  tick, sample, hold, done);
    modport gen (input run, slow, rate, output tick);
    modport seq (input tick, run, restart, output sample, hold, done);
endinterface

/* acc_tick_gen.sv */
// converter clock enable from the cpu clock
`timescale 1ns/1ps
module acc_tick_gen
    import acc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    acc_seq_if.gen   t
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       tick;
    } acc_tick_st_t;

    acc_tick_st_t s_q;
    acc_tick_st_t s_d;
    logic [1:0]   lim;

    always_comb begin
        if (t.slow) begin
            lim = DIV_QUARTER_M1;
        end else if (t.rate) begin
            lim = DIV_FULL_M1;
        end else begin
            lim = DIV_HALF_M1;
        end
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (!t.run) begin
            s_d.cnt = 2'h0;
        end else if (s_q.cnt >= lim) begin
            s_d.cnt  = 2'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign t.tick = s_q.tick;
endmodule // acc_tick_gen

/* acc_phase_seq.sv */
// sample and hold phase sequencer
`timescale 1ns/1ps
module acc_phase_seq
    import acc_pkg::*;
#(
    parameter int SAMPLE_N = SAMPLE_TICKS,
    parameter int HOLD_N   = HOLD_TICKS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    acc_seq_if.seq   t
);
    typedef struct packed {
        acc_phase_t ph;
        logic [3:0] cnt;
        logic       done;
    } acc_seq_st_t;

    acc_seq_st_t s_q;
    acc_seq_st_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (!t.run) begin
            s_d.ph  = ACC_IDLE;
            s_d.cnt = 4'h0;
        end else if (t.restart) begin
            s_d.ph  = ACC_SAMPLE;
            s_d.cnt = 4'h0;
        end else if (t.tick) begin
            case (s_q.ph)
                ACC_IDLE: begin
                    s_d.ph  = ACC_SAMPLE;
                    s_d.cnt = 4'h0;
                end
                ACC_SAMPLE: begin
                    if (s_q.cnt == 4'(SAMPLE_N - 1)) begin
                        s_d.ph  = ACC_HOLD;
                        s_d.cnt = 4'h0;
                    end else begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                end
                ACC_HOLD: begin
                    if (s_q.cnt == 4'(HOLD_N - 1)) begin
                        s_d.ph   = ACC_SAMPLE;
                        s_d.cnt  = 4'h0;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                end
                default: begin
                    s_d.ph  = ACC_IDLE;
                    s_d.cnt = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign t.sample = (s_q.ph == ACC_SAMPLE);
    assign t.hold   = (s_q.ph == ACC_HOLD);
    assign t.done   = s_q.done;

    AST_HOLD_LEN: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.done |-> $past(s_q.ph) == ACC_HOLD
                     && $past(s_q.cnt) == 4'(HOLD_N - 1))
        else $error("completion without a full hold phase");
endmodule // acc_phase_seq

/* acc_ana_model.sv */
// behavioural analog sample and hold core
`timescale 1ns/1ps
module acc_ana_model
    import acc_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             ana_power,
    input  wire logic [CH_W-1:0]  ana_channel,
    input  wire logic             ana_sample,
    input  wire logic             ana_hold,
    output logic      [RES_W-1:0] ana_result
);
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ana_result <= 10'h155;
        end else if (!ana_power || ana_sample) begin
            ana_result <= ~ana_result;
        // hold phase shows the selected input's code
        end else if (ana_hold) begin
            ana_result <= {ana_channel, ana_channel, ana_channel, 1'b1};
        end
    end
endmodule // acc_ana_model

/* test_adc_conversion_control.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_adc_conversion_control
    import acc_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic              halt_mode = 1'b0;
    logic [7:0]        reg_rdata;
    logic [RES_W-1:0]  ana_result;
    logic              ana_power;
    logic [CH_W-1:0]   ana_channel;
    logic              ana_sample;
    logic              ana_hold;
    logic              irq;
    int                n_fail = 0;
    int                num_checks = 0;
    int                hold_len = 0;
    int                hold_cnt = 0;
    int                samp_cnt = 0;
    int                dv;
    logic              sl;
    logic              rt;
    logic [7:0]        rv;
    logic [RES_W-1:0]  e;

    always #10 sys_clk = ~sys_clk;

    acc_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .halt_mode(halt_mode),
        .ana_result(ana_result), .ana_power(ana_power),
        .ana_channel(ana_channel), .ana_sample(ana_sample),
        .ana_hold(ana_hold), .irq(irq));
    acc_ana_model i_ana (.sys_clk(sys_clk), .rst_n(rst_n),
        .ana_power(ana_power), .ana_channel(ana_channel),
        .ana_sample(ana_sample), .ana_hold(ana_hold),
        .ana_result(ana_result));

    // phase length monitor
    always @(posedge sys_clk) begin
        if (ana_sample)
            samp_cnt++;
        if (ana_hold) begin
            hold_cnt++;
        end else if (hold_cnt != 0) begin
            hold_len = hold_cnt;
            hold_cnt = 0;
        end
    end

    function automatic logic [RES_W-1:0] res_of(input logic [2:0] c);
        return {c, c, c, 1'b1};
    endfunction

    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [15:0] s,
                       input logic [15:0] x);
        num_checks++;
        if (s !== x) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", w, x, s);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rc(input string w, input logic [15:0] a,
                      input logic [7:0] x);
        logic [7:0] d;
        rd(a, d);
        chk(w, 16'(d), 16'(x));
    endtask

    task automatic wait_flag();
        int k;
        k = 0;
        rv = 8'h00;
        while (rv[CSR_FLAG] !== 1'b1 && k < 300) begin
            rd(OFS_CSR, rv);
            k++;
        end
        chk("done flag", 16'(rv[CSR_FLAG]), 16'h1);
    endtask

    task automatic high_ok(input logic [2:0] c);
        logic [RES_W-1:0] r;
        r = res_of(c);
        wait_flag();
        rc("high result", OFS_RES_HI, r[9:2]);
    endtask

    // watchdog, a few times the expected run length
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        test_done();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 5; a++)
            rc("reset value", OFS_CSR + 16'(a), 8'h00);
        wr(16'h0040, 8'hff);
        rc("unmapped", 16'h0040, 8'h00);
        // every clock rate, ten bit read
        for (int i = 0; i < 4; i++) begin
            sl = i[1];
            rt = i[0];
            dv = sl ? 4 : (rt ? 1 : 2);
            e = res_of(3'(i));
            wr(OFS_RES_LO, {4'hf, sl, 3'h7});
            wr(OFS_CSR, {1'b0, rt, 1'b1, 2'b00, 3'(i)});
            wait_flag();
            chk("hold length", 16'(hold_len), 16'(8 * dv));
            rc("low result", OFS_RES_LO, {4'h0, sl, 1'b0, e[1:0]});
            rc("csr after low", OFS_CSR, {2'b10 | 2'(rt), 3'b100,
                                          3'(i)});
            rc("high result", OFS_RES_HI, e[9:2]);
        end
        wr(OFS_CSR, 8'h24);
        chk("restart", 16'(ana_sample), 16'h1);
        chk("channel", 16'(ana_channel), 16'h4);
        high_ok(3'h4);
        rc("flag after high", OFS_CSR, 8'h24);
        wait_flag();
        wr(OFS_CSR, 8'h21);
        chk("new channel", 16'(ana_channel), 16'h1);
        rc("flag after change", OFS_CSR, 8'h21);
        high_ok(3'h1);
        wait_flag();
        wr(OFS_CSR, 8'hba);
        chk("rewrite restart", 16'(ana_sample), 16'h1);
        rc("read only bits", OFS_CSR, 8'h22);
        repeat (2) high_ok(3'h2);
        chk("irq masked", 16'(irq), 16'h0);
        wr(OFS_IRQ_STAT, 8'h01);
        wr(OFS_IRQ_MASK, 8'h01);
        wait_flag();
        @(posedge sys_clk);
        #1;
        chk("irq raised", 16'(irq), 16'h1);
        rc("irq status", OFS_IRQ_STAT, 8'h01);
        wr(OFS_IRQ_MASK, 8'h00);
        @(posedge sys_clk);
        #1;
        chk("irq mask", 16'(irq), 16'h0);
        wr(OFS_CSR, 8'h03);
        chk("power off", 16'(ana_power), 16'h0);
        wr(OFS_IRQ_STAT, 8'h01);
        samp_cnt = 0;
        repeat (200) @(posedge sys_clk);
        chk("samples off", 16'(samp_cnt), 16'h0);
        rc("csr off", OFS_CSR, 8'h03);
        rc("irq clear", OFS_IRQ_STAT, 8'h00);
        wr(OFS_CSR, 8'h23);
        @(posedge sys_clk);
        halt_mode <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk("halt power", 16'(ana_power), 16'h0);
        samp_cnt = 0;
        repeat (200) @(posedge sys_clk);
        chk("halt samples", 16'(samp_cnt), 16'h0);
        halt_mode <= 1'b0;
        high_ok(3'h3);
        test_done();
    end
endmodule // test_adc_conversion_control
